// ==== dv/tb_top.sv ====
// Purpose: Self-checking bench for the terminal input packetizer.
// Assumes: Tick shortened to 20 cycles so timeouts stay short.
// Notes:   Registers over APB, terminal bytes from the host model.
`include "tip_map.vh"
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        pclk = 1'b0;     // 20 MHz clock
  logic        presetn = 1'b0;  // Reset, active low
  logic        psel = 1'b0;     // APB request
  logic        penable = 1'b0;  // APB access phase
  logic        pwrite = 1'b0;   // APB direction
  logic [7:0]  paddr = 8'h00;   // APB address
  logic [31:0] pwdata = 32'h0;  // APB write data
  logic        rx_done = 1'b0;  // Frame end pulse
  logic        rx_crc_ok = 1'b0; // Frame CRC result
  logic [12:0] rx_bits = 13'h0; // Frame length
  logic [31:0] prdata;
  logic [7:0]  term_data, pkt_data, echo_data;
  logic        pready, pslverr, term_valid, term_ready, pkt_valid, pkt_last, echo_valid;
  logic        flow_release, parity_en, parity_odd, rx_accept, rx_discard, heard_station_log;
  logic [31:0] rd;              // Last read data
  logic        err;             // Last error flag
  logic [7:0]  pq[$];           // Packet bytes seen
  logic [7:0]  eq[$];           // Echo bytes seen
  int          np = 0;          // Packets closed
  int          failures = 0;
  int          samples_checked = 0;
  int          i;
  logic [7:0]  ra[5] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10};
  logic [7:0]  rv[5] = '{8'h40, 8'h0A, 8'h16, 8'h12, 8'h80};
  logic [1:0]  pv[4] = '{2'h0, 2'h3, 2'h0, 2'h2};
  logic [15:0] rc[6] = '{16'h6050, 16'h0050, 16'hA050, 16'h8051, 16'hAA98, 16'h8AA0};
  logic [7:0]  ev[5] = '{8'h5C, 8'h0D, 8'h0A, 8'h41, 8'h42};
  logic [7:0]  tc[4] = '{8'h46, 8'h42, 8'h41, 8'h4D};
  int          tl[4] = '{40, 70, 0, 40};
  int          th[4] = '{64, 100, 0, 64};

  always #25 pclk = ~pclk;

  tip_top #(.TICK_CYCLES(20), .DEPTH(256)) i_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .term_valid(term_valid), .term_data(term_data), .term_ready(term_ready),
    .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_last(pkt_last), .echo_valid(echo_valid),
    .echo_data(echo_data), .flow_release(flow_release), .parity_en(parity_en),
    .parity_odd(parity_odd), .rx_done(rx_done), .rx_crc_ok(rx_crc_ok), .rx_bits(rx_bits),
    .rx_accept(rx_accept), .rx_discard(rx_discard), .heard_station_log(heard_station_log)
  );
  tip_term_host i_host (.pclk(pclk), .term_ready(term_ready), .term_valid(term_valid), .term_data(term_data));

  // Collect packet and echo bytes as they leave
  always @(posedge pclk)
  begin
    if (pkt_valid === 1'b1) pq.push_back(pkt_data);
    if (pkt_last === 1'b1) np++;
    if (echo_valid === 1'b1) eq.push_back(echo_data);
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask

  // One APB transfer: setup, then access until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, a, {24'h0, d});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  // Pulse one frame end and look at the verdict
  task automatic rx(input logic [15:0] c);
    wr(`TIP_CTRL_ADDR, {c[15], 7'h40});
    repeat (3) @(posedge pclk);
    chk({31'h0, heard_station_log}, {31'h0, ~c[15]});
    rx_done <= 1'b1;
    rx_crc_ok <= c[14];
    rx_bits <= c[12:0];
    @(posedge pclk);
    rx_done <= 1'b0;
    @(posedge pclk);
    chk({30'h0, rx_accept, rx_discard}, {30'h0, c[13], ~c[13]});
  endtask

  // One byte sent with zero timeout
  task automatic pk(input logic [7:0] c, input logic [7:0] b, input logic [7:0] e);
    wr(`TIP_CTRL_ADDR, c);
    pq.delete();
    i_host.send(b, 0);
    repeat (6) @(posedge pclk);
    chk(pq.size(), 1);
    chk(pq[0], e);
  endtask

  // Two bytes 30 cycles apart, time to first packet byte
  task automatic tmo(input logic [7:0] c, input int lo, input int hi);
    time t0;
    int n;
    wr(`TIP_CTRL_ADDR, c);
    pq.delete();
    i_host.send(8'h31, 0);
    t0 = $time;
    i_host.send(8'h32, 30);
    while (pq.size() == 0 && $time - t0 < 6000) @(posedge pclk);
    n = int'(($time - t0) / 50);
    repeat (4) @(posedge pclk);
    chk(32'(n >= lo && n <= hi), 32'(hi > 0));
    chk(pq.size(), (hi > 0) ? 2 : 0);
    wr(`TIP_CMD_ADDR, 8'h01);
    repeat (3) @(posedge pclk);
  endtask

  task automatic results;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Watchdog against a hung handshake
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    results;
  end

  // Main sequence
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; i < 5; i++) rdc(ra[i], {24'h0, rv[i]});
    rdc(8'h1C, 32'h0);
    chk(err, 1);
    wr(`TIP_TIMEOUT_ADDR, 8'hFF);
    rdc(`TIP_TIMEOUT_ADDR, 32'hFA);
    wr(`TIP_TIMEOUT_ADDR, 8'hFA);
    rdc(`TIP_TIMEOUT_ADDR, 32'hFA);
    wr(`TIP_TIMEOUT_ADDR, 8'h00);
    for (i = 0; i < 4; i++)
    begin
      wr(`TIP_CTRL_ADDR, 8'h40 | (i << 4));
      repeat (3) @(posedge pclk);
      chk({parity_en, parity_odd}, pv[i]);
    end
    for (i = 0; i < 6; i++) rx(rc[i]);
    pk(8'h42, 8'hC5, 8'hC5);
    pk(8'h02, 8'hC5, 8'h45);
    pk(8'h12, 8'hC5, 8'hC5);
    wr(`TIP_CTRL_ADDR, 8'h40);
    wr(`TIP_MAXLEN_ADDR, 8'h02);
    pq.delete();
    np = 0;
    i_host.send(8'h81, 0);
    i_host.send(8'h16, 0);
    i_host.send(8'h12, 0);
    repeat (6) @(posedge pclk);
    chk(np, 1);
    chk(pq.size(), 2);
    chk(pq[0], 8'h01);
    chk(pq[1], 8'h12);
    wr(`TIP_MAXLEN_ADDR, 8'h00);
    np = 0;
    i_host.send(8'h41, 0);
    i_host.send(8'h42, 0);
    i_host.send(8'h12, 0);
    repeat (12) @(posedge pclk);
    chk(np, 0);
    chk(eq.size(), 5);
    for (i = 0; i < 5; i++) chk(eq[i], ev[i]);
    wr(`TIP_CMD_ADDR, 8'h01);
    repeat (3) @(posedge pclk);
    rdc(`TIP_MAXLEN_ADDR, 32'h0);
    rdc(`TIP_STATUS_ADDR, 32'h400);
    wr(`TIP_CTRL_ADDR, 8'h42);
    wr(`TIP_TIMEOUT_ADDR, 8'h03);
    pq.delete();
    repeat (100) @(posedge pclk);
    chk(pq.size(), 0);
    for (i = 0; i < 4; i++) tmo(tc[i], tl[i], th[i]);
    wr(`TIP_CMD_ADDR, 8'h02);
    repeat (3) @(posedge pclk);
    rdc(`TIP_TIMEOUT_ADDR, 32'h0A);
    rdc(`TIP_CTRL_ADDR, 32'h40);
    results;
  end
endmodule
`default_nettype wire

// ==== dv/tip_chk_assertions.sv ====
// Purpose: Concurrent checks on the ports of the terminal input packetizer.
// Assumes: One pclk domain, presetn asynchronous and active low.
// Notes:   Bound to tip_top; watches its ports, both what the bench drives and what the design drives.
`include "tip_map.vh"
`default_nettype none
module tip_chk (
  input wire logic        pclk,               // System clock
  input wire logic        presetn,            // Reset, active low
  input wire logic        psel,               // APB select
  input wire logic        penable,            // APB enable
  input wire logic        pwrite,             // APB write
  input wire logic        pready,             // APB ready
  input wire logic [7:0]  paddr,              // APB address
  input wire logic [31:0] pwdata,             // APB write data
  input wire logic        rx_done,            // Frame ended
  input wire logic        rx_crc_ok,          // Frame CRC good
  input wire logic [12:0] rx_bits,            // Frame length in bits
  input wire logic        rx_accept,          // Frame kept
  input wire logic        rx_discard,         // Frame dropped
  input wire logic        heard_station_log,  // Heard log on
  input wire logic        parity_en,          // Parity on
  input wire logic        parity_odd,         // Odd parity
  input wire logic        flow_release,       // Flow release pulse
  input wire logic        echo_valid,         // Echo byte out
  input wire logic [7:0]  echo_data,          // Echo byte
  input wire logic        pkt_valid,          // Packet byte out
  input wire logic        pkt_last            // Last packet byte
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // Completed write to the control word
  logic ctrl_wr;
  assign ctrl_wr = psel && penable && pready && pwrite && paddr == `TIP_CTRL_ADDR;

  a_rx_good_take: assert property (rx_done && rx_crc_ok |=> rx_accept && !rx_discard)
    else $error("good frame not accepted");
  a_rx_bad_drop: assert property (rx_done && !rx_crc_ok && heard_station_log |=> rx_discard)
    else $error("bad frame kept without pass-through");
  a_rx_odd_bits: assert property (rx_done && !rx_crc_ok && rx_bits[2:0] != 3'h0 |=> rx_discard)
    else $error("bad frame with partial byte kept");
  a_rx_too_long: assert property (rx_done && !rx_crc_ok && rx_bits > `TIP_RX_MAX_BITS |=> rx_discard)
    else $error("oversize bad frame kept");
  a_rx_no_stray: assert property (!rx_done |=> !(rx_accept || rx_discard))
    else $error("frame verdict without frame");
  a_heard_follow: assert property (ctrl_wr |-> ##2 heard_station_log == !$past(pwdata[7], 2))
    else $error("heard log does not follow pass-through");
  a_parity_map: assert property (ctrl_wr |-> ##2 parity_en == $past(pwdata[4], 2) &&
    parity_odd == $past(pwdata[4] && !pwdata[5], 2))
    else $error("parity outputs wrong for setting");
  a_echo_head: assert property ($rose(flow_release) |=> echo_valid && echo_data == `TIP_CH_BSLASH
    ##1 echo_valid && echo_data == `TIP_CH_CR ##1 echo_valid && echo_data == `TIP_CH_LF)
    else $error("redisplay echo head wrong");
  a_flow_pulse: assert property (flow_release |=> !flow_release)
    else $error("flow release longer than one cycle");
  a_last_in_pkt: assert property (pkt_last |-> pkt_valid)
    else $error("last flag without packet byte");

  c_rx_accept: cover property (rx_done && !rx_crc_ok ##1 rx_accept);
  c_redisplay: cover property (flow_release);
  c_pkt_end: cover property (pkt_last);
endmodule

bind tip_top tip_chk i_chk (.*);
`default_nettype wire

// ==== dv/tip_term_host.sv ====
// Purpose: Host terminal model offering bytes on the valid/ready input.
// Assumes: Bytes change just after a rising edge.
// Notes:   A released data line shows the inverse byte, never a stale copy.
`default_nettype none
module tip_term_host (
  input  wire logic       pclk,        // System clock
  input  wire logic       term_ready,  // Device takes byte
  output var  logic       term_valid,  // Byte offered
  output var  logic [7:0] term_data    // Byte value
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    term_valid = 1'b0;
    term_data  = 8'hA5;
  end
  // Wait gap cycles, then hold the byte until it is taken
  task automatic send(input logic [7:0] b, input int gap);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    term_valid <= 1'b1;
    term_data  <= b;
    do
      @(posedge pclk);
    while (term_ready !== 1'b1);
    term_valid <= 1'b0;
    term_data  <= ~b;
  endtask
endmodule
`default_nettype wire

// ==== rtl/tip_linebuf.v ====
// Purpose: Flip-flop line store holding the bytes of the packet being assembled.
// Assumes: One write port, one combinational read port.
// Notes:   Contents are not cleared; the fill count elsewhere says what is valid.
`default_nettype none
module tip_linebuf #(
  parameter DEPTH = 256,  // Entries
  parameter AW    = 8     // Index width
) (
  input  wire          pclk,     // System clock
  input  wire          wr_en,    // Write strobe
  input  wire [AW-1:0] wr_idx,   // Write index
  input  wire [7:0]    wr_data,  // Write byte
  input  wire [AW-1:0] rd_idx,   // Read index
  output wire [7:0]    rd_data   // Read byte
);
  wire [8*DEPTH-1:0] flat;  // All entries side by side

  genvar i;
  generate
    for (i = 0; i < DEPTH; i = i + 1)
    begin : g_ent
      reg [7:0] ent;  // One stored byte
      // Store byte when addressed
      always @(posedge pclk)
      begin
        if (wr_en && (wr_idx == i))
          ent <= wr_data;
      end
      assign flat[8*i +: 8] = ent;
    end
  endgenerate

  assign rd_data = flat[8*rd_idx +: 8];
endmodule
`default_nettype wire

// ==== rtl/tip_map.vh ====
// Purpose: Constants of the terminal input packetizer: register map, fields, defaults, timing.
// Assumes: Included by bare name from the top-level design file, the bench top and the assertion file.
// Notes:   Definitions only; byte addresses of the APB register words.
`ifndef TIP_MAP_VH
`define TIP_MAP_VH
// Register byte addresses
`define TIP_CTRL_ADDR      8'h00
`define TIP_TIMEOUT_ADDR   8'h04
`define TIP_PASS_ADDR      8'h08
`define TIP_REDISP_ADDR    8'h0C
`define TIP_MAXLEN_ADDR    8'h10
`define TIP_CMD_ADDR       8'h14
`define TIP_STATUS_ADDR    8'h18
// Control register field positions
`define TIP_CTRL_MODE_LO   0
`define TIP_CTRL_MODE_HI   1
`define TIP_CTRL_EVERY     2
`define TIP_CTRL_CONV_TMO  3
`define TIP_CTRL_PAR_LO    4
`define TIP_CTRL_PAR_HI    5
`define TIP_CTRL_WLEN8     6
`define TIP_CTRL_CRC_PASS  7
// Command register bits
`define TIP_CMD_RESTART    0
`define TIP_CMD_RESET      1
// Operating modes
`define TIP_MODE_CMD       2'h0
`define TIP_MODE_CONV      2'h1
`define TIP_MODE_TRANS     2'h2
// Reset values and timeout maximum
`define TIP_CTRL_RST       8'h40
`define TIP_TIMEOUT_RST    8'h0A
`define TIP_TIMEOUT_MAX    8'hFA
`define TIP_PASS_RST       7'h16
`define TIP_REDISP_RST     7'h12
`define TIP_MAXLEN_RST     8'h80
// Echo characters
`define TIP_CH_BSLASH      8'h5C
`define TIP_CH_CR          8'h0D
`define TIP_CH_LF          8'h0A
// Received frame limits
`define TIP_RX_MAX_BYTES   339
`define TIP_RX_MAX_BITS    13'h0A98
// Timing
`define TIP_CLK_KHZ        20000
`define TIP_TICK_MS        100
`define TIP_TICK_CYCLES    (`TIP_TICK_MS * `TIP_CLK_KHZ)
`endif

// ==== rtl/tip_tick.v ====
// Purpose: Prescaler giving a one-cycle 100 ms tick from the system clock.
// Assumes: pclk at the rate of the block; CYCLES at least 2.
// Notes:   Free running; the first tick comes CYCLES edges after reset.
`default_nettype none
module tip_tick #(
  parameter CYCLES = 2000000,  // Clock cycles per tick
  parameter CNT_W  = 24        // Counter width
) (
  input  wire             pclk,     // System clock
  input  wire             presetn,  // Async reset, active low
  output reg              tick      // One-cycle tick pulse
);
  localparam [CNT_W-1:0] LAST = CYCLES - 1;  // Terminal count

  reg [CNT_W-1:0] cnt;  // Cycle counter

  // Count cycles and pulse at wrap
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt  <= {CNT_W{1'b0}};
      tick <= 1'b0;
    end
    else if (cnt == LAST)
    begin
      cnt  <= {CNT_W{1'b0}};
      tick <= 1'b1;
    end
    else
    begin
      cnt  <= cnt + 1'b1;
      tick <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/tip_top.v ====
// Purpose: Terminal input packetizer with APB control, timeouts, editing and frame filter.
// Assumes: Terminal bytes arrive synchronous to pclk with valid/ready.
// Notes:   Packets leave one byte per cycle once closed; input stalls meanwhile.
`include "tip_map.vh"
`default_nettype none
// What this block does
// - Holds timeout setting 0..250 in 100 ms
// - Every mode flushes each n ticks
// - After mode flushes on n idle ticks
// - No empty packets; timer starts at first byte
// - Zero timeout packetizes at once
// - Timeout always transparent, conversational only if enabled
// - Parity 0,2 none; 1 odd; 3 even
// - Command/conversational strip parity bit unchecked
// - Transparent keeps all eight bits with parity or 8-bit words
// - Transparent, no parity, 7-bit: bit7 zero
// - Pass character inserts next char literally
// - Pass-through off: accept only good CRC
// - Pass-through on: bad CRC if whole bytes, <=339
// - Heard log suspended during pass-through
// - Redisplay: release flow, backslash, retype line
// - Restart reinitialises, settings kept
// - Reset restores defaults then reinitialises
// - Full packet at max length; zero means 256
module tip_top #(
  parameter TICK_CYCLES = `TIP_TICK_CYCLES,  // Cycles per 100 ms tick
  parameter DEPTH       = 256                // Line store entries
) (
  input  wire        pclk,          // System clock, 20 MHz
  input  wire        presetn,       // Async reset, active low
  input  wire        psel,          // APB select
  input  wire        penable,       // APB enable
  input  wire        pwrite,        // APB write
  input  wire [7:0]  paddr,         // APB byte address
  input  wire [31:0] pwdata,        // APB write data
  output reg  [31:0] prdata,        // APB read data
  output reg         pready,        // APB ready
  output reg         pslverr,       // APB error, unmapped address
  input  wire        term_valid,    // Terminal byte present
  input  wire [7:0]  term_data,     // Terminal byte
  output reg         term_ready,    // Terminal byte taken
  output reg         pkt_valid,     // Packet byte out
  output reg  [7:0]  pkt_data,      // Packet byte
  output reg         pkt_last,      // Last byte of packet
  output reg         echo_valid,    // Echo byte to terminal
  output reg  [7:0]  echo_data,     // Echo byte
  output reg         flow_release,  // Pulse: release type-in flow control
  output reg         parity_en,     // Terminal parity enabled
  output reg         parity_odd,    // Odd when set, else even
  input  wire        rx_done,       // Pulse: received frame ended
  input  wire        rx_crc_ok,     // Frame CRC valid
  input  wire [12:0] rx_bits,       // Frame length in bits
  output reg         rx_accept,     // Pulse: frame accepted
  output reg         rx_discard,    // Pulse: frame discarded
  output reg         heard_station_log  // Heard log enabled
);
  // FSM states
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_FLUSH = 3'h1;
  localparam [2:0] ST_BS    = 3'h2;
  localparam [2:0] ST_CR    = 3'h3;
  localparam [2:0] ST_LF    = 3'h4;
  localparam [2:0] ST_LINE  = 3'h5;
  // Settings
  reg [7:0] ctrl;                    // Control fields
  reg [7:0] packet_timeout_setting;  // Timeout in ticks
  reg [6:0] pass_char;               // Literal-pass escape
  reg [6:0] redisplay_line_char;     // Redisplay character
  reg [7:0] max_packet_length;       // Full-packet length
  reg       soft_init;               // Pulse: reinitialise runtime state
  // Runtime state
  reg [2:0] state;    // Sequencer state
  reg [8:0] fill;     // Bytes in current packet
  reg [7:0] rd_idx;   // Read index for flush and echo
  reg [7:0] tmo_cnt;  // Elapsed ticks
  reg       escaped;  // Next char is literal
  wire       tick;     // 100 ms pulse
  wire [7:0] rd_byte;  // Line store read
  // Decoded control fields
  wire [1:0] op_mode  = ctrl[`TIP_CTRL_MODE_HI:`TIP_CTRL_MODE_LO];
  wire       every    = ctrl[`TIP_CTRL_EVERY];
  wire       conversational_timeout_enable = ctrl[`TIP_CTRL_CONV_TMO];
  wire [1:0] par_set  = ctrl[`TIP_CTRL_PAR_HI:`TIP_CTRL_PAR_LO];
  wire       terminal_word_length = ctrl[`TIP_CTRL_WLEN8];  // 1 = 8 bits
  wire       crc_pass_through = ctrl[`TIP_CTRL_CRC_PASS];
  wire       transp   = (op_mode == `TIP_MODE_TRANS);
  // Timeout applies in transparent, or conversational with enable
  wire tmo_on = transp || ((op_mode == `TIP_MODE_CONV) && conversational_timeout_enable);
  // Bit 7 survives only in transparent mode with parity or 8-bit words
  wire [7:0] in_ch = {term_data[7] && transp && (par_set[0] || terminal_word_length), term_data[6:0]};
  // Byte taken this cycle and its meaning
  wire take    = term_valid && term_ready && (state == ST_IDLE);
  wire special = !transp && !escaped;
  wire is_pass = special && (in_ch[6:0] == pass_char);
  wire is_redi = special && (in_ch[6:0] == redisplay_line_char);
  wire store   = take && !is_pass && !is_redi;
  // Packet length limit, zero meaning 256
  wire [8:0] limit = (max_packet_length == 8'h00) ? 9'h100 : {1'b0, max_packet_length};
  wire [8:0] fill_inc = fill + 9'h001;
  wire [8:0] last_idx = fill - 9'h001;
  // Periodic or idle expiry on a tick
  wire [7:0] tmo_inc = tmo_cnt + 8'h01;
  wire expire = tick && tmo_on && (fill != 9'h000) && (tmo_inc >= packet_timeout_setting);
  // Tick prescaler
  tip_tick #(.CYCLES (TICK_CYCLES)) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .tick    (tick)
  );
  // Current line store
  tip_linebuf #(.DEPTH (DEPTH)) u_buf (
    .pclk    (pclk),
    .wr_en   (store),
    .wr_idx  (fill[7:0]),
    .wr_data (in_ch),
    .rd_idx  (rd_idx),
    .rd_data (rd_byte)
  );
  // APB decode; every aligned word up to status is mapped
  wire setup = psel && !penable;
  wire wr_acc = psel && penable && pwrite && pready;
  wire mapped = (paddr <= `TIP_STATUS_ADDR) && (paddr[1:0] == 2'h0);
  // Read mux
  reg [31:0] next_prdata;
  always @*
  begin
    next_prdata = 32'h00000000;
    case (paddr)
      `TIP_CTRL_ADDR:    next_prdata[7:0] = ctrl;
      `TIP_TIMEOUT_ADDR: next_prdata[7:0] = packet_timeout_setting;
      `TIP_PASS_ADDR:    next_prdata[6:0] = pass_char;
      `TIP_REDISP_ADDR:  next_prdata[6:0] = redisplay_line_char;
      `TIP_MAXLEN_ADDR:  next_prdata[7:0] = max_packet_length;
      `TIP_STATUS_ADDR:  next_prdata[10:0] = {heard_station_log, (state != ST_IDLE), fill};
      default:           next_prdata = 32'h00000000;
    endcase
  end
  // APB answer: data and error sampled in setup, ready high from the first cycle after reset
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= 1'b1;
      if (setup)
      begin
        prdata  <= pwrite ? 32'h00000000 : next_prdata;
        pslverr <= !mapped;
      end
    end
  end
  // Settings and restart/reset commands
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl                   <= `TIP_CTRL_RST;
      packet_timeout_setting <= `TIP_TIMEOUT_RST;
      pass_char              <= `TIP_PASS_RST;
      redisplay_line_char    <= `TIP_REDISP_RST;
      max_packet_length      <= `TIP_MAXLEN_RST;
      soft_init              <= 1'b0;
    end
    else
    begin
      soft_init <= 1'b0;
      if (wr_acc)
      begin
        case (paddr)
          `TIP_CTRL_ADDR:    ctrl <= pwdata[7:0];
          // Values above 250 clamp to 250
          `TIP_TIMEOUT_ADDR: packet_timeout_setting <= (pwdata[7:0] > `TIP_TIMEOUT_MAX)
                                                       ? `TIP_TIMEOUT_MAX : pwdata[7:0];
          `TIP_PASS_ADDR:    pass_char <= pwdata[6:0];
          `TIP_REDISP_ADDR:  redisplay_line_char <= pwdata[6:0];
          `TIP_MAXLEN_ADDR:  max_packet_length <= pwdata[7:0];
          `TIP_CMD_ADDR:
          begin
            if (pwdata[`TIP_CMD_RESET])
            begin
              ctrl                   <= `TIP_CTRL_RST;
              packet_timeout_setting <= `TIP_TIMEOUT_RST;
              pass_char              <= `TIP_PASS_RST;
              redisplay_line_char    <= `TIP_REDISP_RST;
              max_packet_length      <= `TIP_MAXLEN_RST;
            end
            soft_init <= pwdata[`TIP_CMD_RESET] | pwdata[`TIP_CMD_RESTART];
          end
          default: soft_init <= 1'b0;
        endcase
      end
    end
  end
  // Parity decode, received frame filter and heard log gate
  wire rx_keep = rx_crc_ok || (crc_pass_through && (rx_bits[2:0] == 3'h0)
                 && (rx_bits <= `TIP_RX_MAX_BITS));
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      parity_en         <= 1'b0;
      parity_odd        <= 1'b0;
      rx_accept         <= 1'b0;
      rx_discard        <= 1'b0;
      heard_station_log <= 1'b0;
    end
    else
    begin
      parity_en         <= par_set[0];
      parity_odd        <= (par_set == 2'h1);
      heard_station_log <= !crc_pass_through;
      rx_accept         <= rx_done && rx_keep;
      rx_discard        <= rx_done && !rx_keep;
    end
  end
  // Timeout counter: idle until first byte
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      tmo_cnt <= 8'h00;
    else if (soft_init || (state != ST_IDLE) || (fill == 9'h000))
      tmo_cnt <= 8'h00;
    else if (store && !every)
      tmo_cnt <= 8'h00;
    else if (tick && tmo_on)
      tmo_cnt <= tmo_inc;
  end
  // Input sequencer: accumulate, flush, redisplay
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= ST_IDLE;
      fill         <= 9'h000;
      rd_idx       <= 8'h00;
      escaped      <= 1'b0;
      term_ready   <= 1'b0;
      pkt_valid    <= 1'b0;
      pkt_data     <= 8'h00;
      pkt_last     <= 1'b0;
      echo_valid   <= 1'b0;
      echo_data    <= 8'h00;
      flow_release <= 1'b0;
    end
    else if (soft_init)
    begin
      state        <= ST_IDLE;
      fill         <= 9'h000;
      rd_idx       <= 8'h00;
      escaped      <= 1'b0;
      term_ready   <= 1'b0;
      pkt_valid    <= 1'b0;
      pkt_last     <= 1'b0;
      echo_valid   <= 1'b0;
      flow_release <= 1'b0;
    end
    else
    begin
      pkt_valid    <= 1'b0;
      pkt_last     <= 1'b0;
      echo_valid   <= 1'b0;
      flow_release <= 1'b0;
      case (state)
        ST_IDLE:
        begin
          term_ready <= 1'b1;
          if (take)
          begin
            if (is_pass)
              escaped <= 1'b1;
            else if (is_redi)
            begin
              // Show pending traffic, then retype the line
              flow_release <= 1'b1;
              state        <= ST_BS;
              term_ready   <= 1'b0;
            end
            else
            begin
              escaped <= 1'b0;
              fill    <= fill_inc;
              // Close on full length or zero timeout
              if ((fill_inc == limit) || (tmo_on && (packet_timeout_setting == 8'h00)))
              begin
                state      <= ST_FLUSH;
                rd_idx     <= 8'h00;
                term_ready <= 1'b0;
              end
            end
          end
          else if (expire)
          begin
            state      <= ST_FLUSH;
            rd_idx     <= 8'h00;
            term_ready <= 1'b0;
          end
        end
        ST_FLUSH:
        begin
          // Emit the packet; fill is never zero here
          pkt_valid <= 1'b1;
          pkt_data  <= rd_byte;
          if (rd_idx == last_idx[7:0])
          begin
            pkt_last   <= 1'b1;
            fill       <= 9'h000;
            state      <= ST_IDLE;
            term_ready <= 1'b1;
          end
          else
            rd_idx <= rd_idx + 8'h01;
        end
        ST_BS:
        begin
          echo_valid <= 1'b1;
          echo_data  <= `TIP_CH_BSLASH;
          state      <= ST_CR;
        end
        ST_CR:
        begin
          echo_valid <= 1'b1;
          echo_data  <= `TIP_CH_CR;
          state      <= ST_LF;
        end
        ST_LF:
        begin
          echo_valid <= 1'b1;
          echo_data  <= `TIP_CH_LF;
          rd_idx     <= 8'h00;
          if (fill == 9'h000)
          begin
            state      <= ST_IDLE;
            term_ready <= 1'b1;
          end
          else
            state <= ST_LINE;
        end
        ST_LINE:
        begin
          // Retype the stored line
          echo_valid <= 1'b1;
          echo_data  <= rd_byte;
          if (rd_idx == last_idx[7:0])
          begin
            state      <= ST_IDLE;
            term_ready <= 1'b1;
          end
          else
            rd_idx <= rd_idx + 8'h01;
        end
        default:
        begin
          state      <= ST_IDLE;
          term_ready <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire
